// ---- hdl/cfsic_core.sv ----
`timescale 1ns/100ps
module cfsic_core
#(
   parameter int          NIRQ        = 8,
   parameter int          VEC_WORDS   = 1,
   parameter logic [15:0] TOP_OF_SRAM = cfsic_pkg::TOP_OF_SRAM_DEF,
   parameter logic [15:0] BOOT_START  = cfsic_pkg::BOOT_START_DEF
)
(
   // Clock, reset and enable
   input  wire logic                     clk_sys,
   input  wire logic                     sys_rst,
   input  wire logic                     clk_en,
   // Execution datapath
   input  wire cfsic_pkg::cfsic_exec_t   exec,
   input  wire logic                     sleeping,
   input  wire cfsic_pkg::cfsic_rf_req_t rf_req,
   output      cfsic_pkg::cfsic_rf_rsp_t rf_rsp,
   // I/O register access
   input  wire cfsic_pkg::cfsic_io_t     io,
   output      logic [7:0]               io_rdata,
   // Interrupt sources
   input  wire logic [NIRQ-1:0]          irq_event,
   input  wire logic [NIRQ-1:0]          irq_flag_clr,
   input  wire logic [NIRQ-1:0]          irq_enable,
   input  wire logic [NIRQ-1:0]          irq_level,
   input  wire logic [NIRQ-1:0]          irq_is_level,
   output      logic [NIRQ-1:0]          irq_flags,
   // Vector placement and protection
   input  wire logic                     vector_relocate_sel,
   input  wire logic                     boot_vector_fuse,
   input  wire logic                     app_lock_pair,
   input  wire logic                     loader_lock_pair,
   input  wire logic                     pc_in_boot,
   // Program flow
   output      logic                     busy,
   output      logic                     vec_go,
   output      logic [15:0]              vec_addr,
   output      logic                     pc_load,
   output      logic [15:0]              pc_value,
   // Stack memory port
   output      logic                     stk_we,
   output      logic                     stk_re,
   output      logic [15:0]              stk_addr,
   output      logic [7:0]               stk_wdata,
   input  wire logic [7:0]               stk_rdata,
   // Core state view
   output      logic [7:0]               core_flag_register,
   output      logic [15:0]              stack_pointer
);
   import cfsic_pkg::*;

   localparam int IW = (NIRQ > 1) ? $clog2(NIRQ) : 1;

   // Whole state of the core
   typedef struct packed {
      cfsic_phase_t  phase;     // Sequencer phase
      logic [3:0]    cnt;       // Cycles left in phase
      logic          second;    // High byte push still due
      logic          rst_done;  // Reset vector issued
      logic [7:0]    flags;     // Flag register
      logic [15:0]   sp;        // Stack pointer
      logic [NIRQ-1:0] pend;    // Pending event flags
      logic [7:0]    io_rd;     // I/O read latch
      logic          busy;      // Entry or return running
      logic          vec_go;    // Vector fetch pulse
      logic [15:0]   vec_addr;  // Vector word address
      logic          pc_load;   // Return address pulse
      logic [15:0]   pc_val;    // Return address
      logic          stk_we;    // Stack write strobe
      logic          stk_re;    // Stack read strobe
      logic [15:0]   stk_addr;  // Stack address
      logic [7:0]    stk_wd;    // Stack write data
   } cfsic_state_t;

   localparam cfsic_state_t ST_RST = '{
      phase:    P_IDLE,
      cnt:      '0,
      second:   1'b0,
      rst_done: 1'b0,
      flags:    FLAGS_RST,
      sp:       TOP_OF_SRAM,
      pend:     '0,
      io_rd:    '0,
      busy:     1'b0,
      vec_go:   1'b0,
      vec_addr: VEC_RESET_OFS,
      pc_load:  1'b0,
      pc_val:   '0,
      stk_we:   1'b0,
      stk_re:   1'b0,
      stk_addr: '0,
      stk_wd:   '0
   };

   cfsic_state_t  st;        // Current state
   cfsic_state_t  next_st;   // Next state
   cfsic_rf_req_t rf_in;     // Request with bit-load value

   logic [NIRQ-1:0] req;     // Requests wanting service
   logic [IW-1:0]   sel;     // Winning request
   logic            blocked; // Lock-pair protection active
   logic            kill_ie; // Enable dropping this cycle
   logic            take;    // Start interrupt entry

   // Lowest index wins: lower vector, higher priority
   function automatic logic [IW-1:0] first_set(input logic [NIRQ-1:0] v);
      first_set = '0;
      for (int i = NIRQ - 1; i >= 0; i--)
      begin
         if (v[i])
            first_set = IW'(i);
      end
   endfunction

   // Vector address from table base and vector number
   function automatic logic [15:0] vec_of(input logic boot, input logic [15:0] num);
      vec_of = (boot ? BOOT_START : VEC_RESET_OFS) + 16'(num * VEC_WORDS);
   endfunction

   // Bit loads take the copy store as data
   always_comb
   begin
      rf_in         = rf_req;
      rf_in.bit_we  = exec.done && (exec.op == OP_BLOAD) && (st.phase == P_IDLE);
      rf_in.bit_val = st.flags[F_T];
   end

   // Working registers and pointer pairs
   cfsic_regfile u_regfile
   (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .clk_en  (clk_en),
      .req     (rf_in),
      .rsp     (rf_rsp)
   );

   // Request gathering and the take decision
   always_comb
   begin
      // Flag type waits in pend, level type only while present
      req = ((st.pend & ~irq_is_level) | (irq_level & irq_is_level)) & irq_enable;
      sel = first_set(req);
      // Region-dependent protection by the lock pairs
      blocked = (app_lock_pair && !pc_in_boot) || (loader_lock_pair && pc_in_boot);
      // Disable in flight blocks a take in the same cycle
      kill_ie = (exec.done && (exec.op == OP_CLI))
              || (io.we && (io.addr == IO_FLAGS) && !io.wd[F_I]);
      // Only at an instruction boundary or from sleep; a return
      // never ends at a boundary, so one instruction always follows.
      // Enable set this cycle is not seen until the next boundary.
      take = (st.phase == P_IDLE) && st.rst_done && (exec.done || sleeping)
           && st.flags[F_I] && !kill_ie && (exec.op != OP_IRQ_EXIT)
           && (req != '0) && !blocked;
   end

   // Next-state logic
   always_comb
   begin
      next_st         = st;
      next_st.vec_go  = 1'b0;
      next_st.pc_load = 1'b0;
      next_st.stk_we  = 1'b0;
      next_st.stk_re  = 1'b0;
      // New events set, write-one clears; a new event wins
      next_st.pend = (st.pend & ~irq_flag_clr) | (irq_event & ~irq_is_level);
      // Reset vector issued once after reset release
      if (!st.rst_done)
      begin
         next_st.rst_done = 1'b1;
         next_st.vec_go   = 1'b1;
         next_st.vec_addr = vec_of(boot_vector_fuse, VEC_RESET_OFS);
      end
      // I/O writes; flag register replaced whole except the sign bit, which follows N and V
      if (io.we)
      begin
         case (io.addr)
            IO_SP_LO: next_st.sp[7:0]  = io.wd;
            IO_SP_HI: next_st.sp[15:8] = io.wd;
            IO_FLAGS: next_st.flags    = io.wd;
            default:  ;
         endcase
      end
      // I/O reads, unmapped addresses read zero
      if (io.re)
      begin
         case (io.addr)
            IO_SP_LO: next_st.io_rd = st.sp[7:0];
            IO_SP_HI: next_st.io_rd = st.sp[15:8];
            IO_FLAGS: next_st.io_rd = st.flags;
            default:  next_st.io_rd = '0;
         endcase
      end
      case (st.phase)
         P_IDLE:
         begin
            // Completed instruction effects; ignored while busy
            if (exec.done)
            begin
               case (exec.op)
                  OP_ALU:
                  begin
                     // Each ALU result refreshes the flags its fmask selects; the sign bit follows N and V whatever the fmask
                     if (exec.fmask[F_H])
                        next_st.flags[F_H] = exec.h;
                     if (exec.fmask[F_V])
                        next_st.flags[F_V] = exec.v;
                     if (exec.fmask[F_N])
                        next_st.flags[F_N] = exec.res[7];
                     if (exec.fmask[F_Z])
                        next_st.flags[F_Z] = ~|exec.res;
                     if (exec.fmask[F_C])
                        next_st.flags[F_C] = exec.c;
                  end
                  OP_SEI:   next_st.flags[F_I] = 1'b1;
                  OP_CLI:   next_st.flags[F_I] = 1'b0;
                  OP_BSAVE: next_st.flags[F_T] = exec.t_in;
                  OP_PUSH:  next_st.sp = next_st.sp - STEP1;
                  OP_POP:   next_st.sp = next_st.sp + STEP1;
                  OP_CALL:  next_st.sp = next_st.sp - STEP2;
                  OP_SUB_EXIT: next_st.sp = next_st.sp + STEP2;
                  OP_IRQ_EXIT:
                  begin
                     // First pop: high byte, pushed last
                     next_st.phase    = P_RETURN;
                     next_st.cnt      = 4'(RETURN_CYC);
                     next_st.busy     = 1'b1;
                     next_st.stk_re   = 1'b1;
                     next_st.sp       = next_st.sp + STEP1;
                     next_st.stk_addr = next_st.sp;
                  end
                  default: ;
               endcase
            end
            // Entry: flags untouched, only the enable drops
            if (take)
            begin
               next_st.phase      = P_ENTRY;
               next_st.cnt        = sleeping ? 4'(ENTRY_CYC + SLEEP_XTRA) : 4'(ENTRY_CYC);
               next_st.busy       = 1'b1;
               next_st.flags[F_I] = 1'b0;
               // Vectoring clears the flag unless a new event lands
               next_st.pend[sel]  = irq_event[sel] & ~irq_is_level[sel];
               next_st.stk_we     = 1'b1;
               next_st.stk_addr   = next_st.sp;
               next_st.stk_wd     = exec.pc[7:0];
               next_st.pc_val     = exec.pc;
               next_st.second     = 1'b1;
               next_st.sp         = next_st.sp - STEP1;
               next_st.vec_addr   = vec_of(vector_relocate_sel, 16'(sel) + STEP1);
            end
         end
         P_ENTRY:
         begin
            // Second push: high byte of the return address
            if (st.second)
            begin
               next_st.second   = 1'b0;
               next_st.stk_we   = 1'b1;
               next_st.stk_addr = st.sp;
               next_st.stk_wd   = st.pc_val[15:8];
               next_st.sp       = next_st.sp - STEP1;
            end
            next_st.cnt = st.cnt - 4'h1;
            if (st.cnt == CNT_LAST)
            begin
               next_st.phase  = P_IDLE;
               next_st.busy   = 1'b0;
               next_st.vec_go = 1'b1;
            end
         end
         P_RETURN:
         begin
            // Second read issued while the first one answers
            if (st.cnt == 4'(RETURN_CYC))
            begin
               next_st.stk_re   = 1'b1;
               next_st.sp       = next_st.sp + STEP1;
               next_st.stk_addr = next_st.sp;
            end
            // Memory answers one cycle after each read strobe
            if (st.cnt == CNT_HI)
               next_st.pc_val[15:8] = stk_rdata;
            if (st.cnt == CNT_LO)
               next_st.pc_val[7:0] = stk_rdata;
            next_st.cnt = st.cnt - 4'h1;
            if (st.cnt == CNT_LAST)
            begin
               next_st.phase      = P_IDLE;
               next_st.busy       = 1'b0;
               next_st.pc_load    = 1'b1;
               next_st.flags[F_I] = 1'b1;
            end
         end
         default:
         begin
            next_st.phase = P_IDLE;
            next_st.busy  = 1'b0;
         end
      endcase
      // Sign always follows negative and overflow
      next_st.flags[F_S] = next_st.flags[F_N] ^ next_st.flags[F_V];
   end

   // State register, frozen while the enable is low
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         st <= ST_RST;
      else if (clk_en)
         st <= next_st;
   end

   // Outputs straight from the state register
   assign io_rdata           = st.io_rd;
   assign irq_flags          = st.pend;
   assign busy               = st.busy;
   assign vec_go             = st.vec_go;
   assign vec_addr           = st.vec_addr;
   assign pc_load            = st.pc_load;
   assign pc_value           = st.pc_val;
   assign stk_we             = st.stk_we;
   assign stk_re             = st.stk_re;
   assign stk_addr           = st.stk_addr;
   assign stk_wdata          = st.stk_wd;
   assign core_flag_register = st.flags;
   assign stack_pointer      = st.sp;

endmodule

// ---- hdl/cfsic_pkg.sv ----
package cfsic_pkg;

   // Flag register bit positions
   localparam int F_I = 7;
   localparam int F_T = 6;
   localparam int F_H = 5;
   localparam int F_S = 4;
   localparam int F_V = 3;
   localparam int F_N = 2;
   localparam int F_Z = 1;
   localparam int F_C = 0;

   // I/O addresses of core registers
   localparam logic [5:0] IO_SP_LO = 6'h3D;
   localparam logic [5:0] IO_SP_HI = 6'h3E;
   localparam logic [5:0] IO_FLAGS = 6'h3F;

   // Reset values
   localparam logic [7:0]  FLAGS_RST      = 8'h00;
   localparam logic [15:0] TOP_OF_SRAM_DEF = 16'h04FF;
   localparam logic [15:0] BOOT_START_DEF  = 16'h0C00;
   localparam logic [15:0] VEC_RESET_OFS   = 16'h0000;

   // Pointer pair low-byte addresses
   localparam logic [4:0] PTR_X_LO = 5'h1A;
   localparam logic [4:0] PTR_Y_LO = 5'h1C;
   localparam logic [4:0] PTR_Z_LO = 5'h1E;
   localparam logic [1:0] PTR_SEL_X = 2'h0;
   localparam logic [1:0] PTR_SEL_Y = 2'h1;

   // Steps and timing counts, in clock cycles
   localparam logic [15:0] STEP1      = 16'h0001;
   localparam logic [15:0] STEP2      = 16'h0002;
   localparam int          ENTRY_CYC  = 4;
   localparam int          SLEEP_XTRA = 4;
   localparam int          RETURN_CYC = 4;
   localparam logic [3:0]  CNT_LAST   = 4'h1;
   localparam logic [3:0]  CNT_HI     = 4'h3;
   localparam logic [3:0]  CNT_LO     = 4'h2;

   // Operations reported by the execution datapath
   typedef enum logic [3:0] {
      OP_NONE, OP_ALU, OP_SEI, OP_CLI, OP_BSAVE, OP_BLOAD,
      OP_PUSH, OP_POP, OP_CALL, OP_SUB_EXIT, OP_IRQ_EXIT
   } cfsic_op_t;

   // Core sequencer phases
   typedef enum logic [1:0] {P_IDLE, P_ENTRY, P_RETURN} cfsic_phase_t;

   // Pointer update modes
   typedef enum logic [1:0] {PTR_NONE, PTR_INC, PTR_DEC} cfsic_ptr_op_t;

   // Instruction completion report
   typedef struct packed {
      cfsic_op_t   op;
      logic        done;
      logic [7:0]  res;
      logic        h;
      logic        v;
      logic        c;
      logic [7:0]  fmask;
      logic        t_in;
      logic [15:0] pc;
   } cfsic_exec_t;

   // I/O register access
   typedef struct packed {
      logic       we;
      logic       re;
      logic [5:0] addr;
      logic [7:0] wd;
   } cfsic_io_t;

   // Working register file request
   typedef struct packed {
      logic [4:0]    ra;
      logic [4:0]    rb;
      logic          we8;
      logic          we16;
      logic [4:0]    wa;
      logic [15:0]   wd;
      logic          bit_we;
      logic [2:0]    bit_sel;
      logic          bit_val;
      logic          ds_we;
      logic [4:0]    ds_addr;
      logic [7:0]    ds_wd;
      logic [1:0]    ptr_sel;
      cfsic_ptr_op_t ptr_op;
      logic [5:0]    disp;
   } cfsic_rf_req_t;

   // Working register file answer
   typedef struct packed {
      logic [7:0]  rd_a;
      logic [7:0]  rd_b;
      logic [15:0] rd_w;
      logic [7:0]  ds_rd;
      logic [15:0] eff_addr;
      logic [15:0] ptr_x;
      logic [15:0] ptr_y;
      logic [15:0] ptr_z;
   } cfsic_rf_rsp_t;

endpackage

// ---- hdl/cfsic_regfile.sv ----
`timescale 1ns/100ps
module cfsic_regfile
(
   // Clock and control
   input  wire logic                    clk_sys,
   input  wire logic                    sys_rst,
   input  wire logic                    clk_en,
   // Request and registered answer
   input  wire cfsic_pkg::cfsic_rf_req_t req,
   output      cfsic_pkg::cfsic_rf_rsp_t rsp
);
   import cfsic_pkg::*;

   // Whole state: the 32 registers and the read latches
   typedef struct packed {
      logic [31:0][7:0] regs;
      cfsic_rf_rsp_t    rsp;
   } cfsic_rf_state_t;

   cfsic_rf_state_t st;        // Current state
   cfsic_rf_state_t next_st;   // Next state

   // Low-byte address of a pointer pair
   function automatic logic [4:0] ptr_base(input logic [1:0] sel);
      case (sel)
         PTR_SEL_X: ptr_base = PTR_X_LO;
         PTR_SEL_Y: ptr_base = PTR_Y_LO;
         default:   ptr_base = PTR_Z_LO;
      endcase
   endfunction

   // Pair two registers, low byte at the even address
   function automatic logic [15:0] pair_of(input logic [31:0][7:0] r, input logic [4:0] lo);
      pair_of = {r[{lo[4:1], 1'b1}], r[{lo[4:1], 1'b0}]};
   endfunction

   // Writes, pointer updates and registered reads
   always_comb
   begin
      logic [4:0]  pb;
      logic [15:0] p;
      logic [15:0] np;
      pb = ptr_base(req.ptr_sel);
      p  = pair_of(st.regs, pb);
      np = p;
      next_st = st;
      // Reads see the registers before this cycle's writes
      next_st.rsp.rd_a  = st.regs[req.ra];
      next_st.rsp.rd_b  = st.regs[req.rb];
      next_st.rsp.rd_w  = pair_of(st.regs, req.ra);
      next_st.rsp.ds_rd = st.regs[req.ds_addr];
      // Wide write covers an aligned pair, else a single byte
      if (req.we16)
      begin
         next_st.regs[{req.wa[4:1], 1'b0}] = req.wd[7:0];
         next_st.regs[{req.wa[4:1], 1'b1}] = req.wd[15:8];
      end
      else if (req.we8)
      begin
         next_st.regs[req.wa] = req.wd[7:0];
      end
      // Single bit loaded from the copy store
      if (req.bit_we)
      begin
         next_st.regs[req.wa][req.bit_sel] = req.bit_val;
      end
      // Data-space store into the register window
      if (req.ds_we)
      begin
         next_st.regs[req.ds_addr] = req.ds_wd;
      end
      // Pointer addressing modes
      case (req.ptr_op)
         PTR_INC:
         begin
            np = p + STEP1;
            next_st.rsp.eff_addr = p;
         end
         PTR_DEC:
         begin
            np = p - STEP1;
            next_st.rsp.eff_addr = np;
         end
         default:
         begin
            next_st.rsp.eff_addr = p + 16'(req.disp);
         end
      endcase
      // Pointer write-back wins over data writes to the same pair
      if (req.ptr_op != PTR_NONE)
      begin
         next_st.regs[{pb[4:1], 1'b0}] = np[7:0];
         next_st.regs[{pb[4:1], 1'b1}] = np[15:8];
      end
      next_st.rsp.ptr_x = pair_of(st.regs, PTR_X_LO);
      next_st.rsp.ptr_y = pair_of(st.regs, PTR_Y_LO);
      next_st.rsp.ptr_z = pair_of(st.regs, PTR_Z_LO);
   end

   // State register, frozen while the enable is low
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         st <= '0;
      else if (clk_en)
         st <= next_st;
   end

   assign rsp = st.rsp;

endmodule

// ---- test/cfsic_core_asserts.sv ----
`timescale 1ns/100ps
module cfsic_core_asserts
(
   // Clock and reset
   input wire logic                   clk_sys,
   input wire logic                   sys_rst,
   // Watched ports
   input wire cfsic_pkg::cfsic_exec_t exec,
   input wire logic                   busy,
   input wire logic                   sleeping,
   input wire logic                   vec_go,
   input wire logic                   pc_load,
   input wire logic                   stk_we,
   input wire logic [7:0]             core_flag_register,
   input wire logic [15:0]            stack_pointer
);
   import cfsic_pkg::*;
   // One domain, nothing judged in reset
   default clocking dc @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // Instruction the core accepts
   wire ok = exec.done && !busy;
   // Entry start, then vector fetch four cycles on
   sequence entry_go;
      $rose(busy) && stk_we;
   endsequence
   sequence vec_fetch;
      ##4 vec_go && !busy;
   endsequence
   // Pointer step; I low so no entry can share the edge
   property sp_step(cfsic_op_t o, logic [15:0] d);
      ok && exec.op == o && !core_flag_register[F_I] |=> stack_pointer == $past(stack_pointer) + d;
   endproperty
   chk_sign_xor:
      assert property (core_flag_register[F_S] == (core_flag_register[F_N] ^ core_flag_register[F_V])) else $error("sign bad");
   chk_entry_push:
      assert property (entry_go |-> !core_flag_register[F_I] ##2 stack_pointer == $past(stack_pointer, 3) - STEP2)
         else $error("entry push bad");
   chk_entry_len:
      assert property (entry_go ##0 !$past(sleeping) |-> vec_fetch) else $error("entry length bad");
   chk_sleep_entry:
      assert property (entry_go ##0 $past(sleeping) |-> ##8 vec_go && !busy) else $error("sleep entry bad");
   chk_flags_kept:
      assert property (entry_go |-> ##4 core_flag_register[6:0] == $past(core_flag_register[6:0], 4))
         else $error("flags touched by entry");
   chk_return_len:
      assert property (ok && exec.op == OP_IRQ_EXIT |-> ##5 pc_load && core_flag_register[F_I]
         && stack_pointer == $past(stack_pointer, 5) + STEP2) else $error("return bad");
   chk_return_gap:
      assert property (pc_load && !exec.done |=> !busy) else $error("entry before next instruction");
   chk_push_one:
      assert property (sp_step(OP_PUSH, -STEP1)) else $error("push step bad");
   chk_call_two:
      assert property (sp_step(OP_CALL, -STEP2)) else $error("call step bad");
   chk_cli_blocks:
      assert property (ok && exec.op == OP_CLI |=> !busy && !core_flag_register[F_I]) else $error("entry after disable");
   chk_sei_defer:
      assert property (ok && exec.op == OP_SEI && !core_flag_register[F_I] |=> !busy && core_flag_register[F_I])
         else $error("entry on enable edge");
endmodule
bind cfsic_core cfsic_core_asserts u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .exec(exec), .busy(busy),
   .vec_go(vec_go), .pc_load(pc_load), .stk_we(stk_we), .core_flag_register(core_flag_register),
   .stack_pointer(stack_pointer), .sleeping(sleeping));

// ---- test/cfsic_stack_mem.sv ----
`timescale 1ns/100ps
module cfsic_stack_mem
(
   // Clock
   input  wire logic        clk_sys,
   // Stack port of the core
   input  wire logic        stk_we,
   input  wire logic        stk_re,
   input  wire logic [15:0] stk_addr,
   input  wire logic [7:0]  stk_wdata,
   output      logic [7:0]  stk_rdata
);
   // Covers the default top of SRAM
   logic [7:0] mem [0:2047];
   // Answer the cycle after a read; scramble otherwise so stale data never passes
   always_ff @(posedge clk_sys)
   begin
      if (stk_we)
         mem[stk_addr[10:0]] <= stk_wdata;
      if (stk_re)
         stk_rdata <= mem[stk_addr[10:0]];
      else
         stk_rdata <= ~stk_rdata;
   end
endmodule

// ---- test/cfsic_core_bench.sv ----
`timescale 1ns/100ps
module cfsic_core_bench;
   import cfsic_pkg::*;
   // Return address handed over at entry
   localparam logic [15:0] PC = 16'h0A5C;
   // Stack instructions and pointer after each
   localparam cfsic_op_t   STK_OP [4] = '{OP_PUSH, OP_CALL, OP_POP, OP_SUB_EXIT};
   localparam logic [15:0] STK_SP [4] = '{16'h047F, 16'h047D, 16'h047E, 16'h0480};
   // Stimulus
   logic        clk_sys = 1'b0;
   logic        sys_rst = 1'b1;
   cfsic_exec_t exec = '0;
   cfsic_io_t   io = '0;
   cfsic_rf_req_t rq = '0;
   logic [7:0]  irq_ev = 8'h00, irq_clr = 8'h00, irq_en = 8'h00, lvl = 8'h00, is_lvl = 8'h00;
   logic        relocate = 1'b0, boot_fuse = 1'b0, app_lock = 1'b0, sleep = 1'b0;
   // Observed outputs
   logic        busy, vec_go, pc_load, stk_we, stk_re;
   logic [15:0] vec_addr, pc_value, stk_addr, stack_pointer;
   logic [7:0]  io_rdata, irq_flags, stk_wdata, stk_rdata, core_flag_register;
   cfsic_rf_rsp_t rsp;
   int          miscompares = 0, n_tests = 0, cycles = 0;
   // Core under test; clock enable and boot-side lock held quiet
   cfsic_core dut
   (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(1'b1), .exec(exec), .sleeping(sleep),
      .rf_req(rq), .rf_rsp(rsp), .io(io), .io_rdata(io_rdata), .irq_event(irq_ev), .irq_flag_clr(irq_clr),
      .irq_enable(irq_en), .irq_level(lvl), .irq_is_level(is_lvl), .irq_flags(irq_flags),
      .vector_relocate_sel(relocate), .boot_vector_fuse(boot_fuse), .app_lock_pair(app_lock),
      .loader_lock_pair(1'b0), .pc_in_boot(1'b0), .busy(busy), .vec_go(vec_go), .vec_addr(vec_addr),
      .pc_load(pc_load), .pc_value(pc_value), .stk_we(stk_we), .stk_re(stk_re), .stk_addr(stk_addr),
      .stk_wdata(stk_wdata), .stk_rdata(stk_rdata), .core_flag_register(core_flag_register),
      .stack_pointer(stack_pointer)
   );
   // Stack memory on the far side
   cfsic_stack_mem u_mem
   (
      .clk_sys(clk_sys), .stk_we(stk_we), .stk_re(stk_re), .stk_addr(stk_addr),
      .stk_wdata(stk_wdata), .stk_rdata(stk_rdata)
   );
   // 10 MHz clock
   initial
   begin
      forever #50 clk_sys = ~clk_sys;
   end
   // Verdict and end of run
   task automatic report_and_stop();
      if (miscompares == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Hang guard, far above the hundred or so cycles needed
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 1000)
      begin
         miscompares++;
         report_and_stop();
      end
   end
   // Drive point just after the rising edge
   task automatic step(int n = 1);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // Compare and count
   task automatic check(logic [15:0] seen, logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One I/O strobe, then an idle cycle
   task automatic io_acc(logic we, logic [5:0] a, logic [7:0] d);
      io = '{we: we, re: !we, addr: a, wd: d};
      step();
      io = '0;
      step();
   endtask
   // One completed instruction, optional source events alongside
   task automatic run(cfsic_op_t o, logic [7:0] r = 8'h00, logic [7:0] m = 8'h00, logic [7:0] ev = 8'h00);
      exec = '{op: o, done: 1'b1, res: r, h: 1'b1, v: 1'b1, c: 1'b1, fmask: m, t_in: 1'b1, pc: PC};
      irq_ev = ev;
      step();
      exec.done = 1'b0;
      irq_ev = 8'h00;
      step();
   endtask
   // Bounded wait for vector fetch or return load
   task automatic wait_pulse(logic ld);
      for (int i = 0; i < 12 && (ld ? pc_load : vec_go) !== 1'b1; i++)
         step();
   endtask
   // Main sequence
   initial
   begin
      step(16);
      sys_rst = 1'b0;
      step(2);
      check(stack_pointer, TOP_OF_SRAM_DEF);
      rq.we16 = 1'b1;
      rq.wa = PTR_X_LO;
      rq.ds_addr = PTR_X_LO;
      rq.wd = 16'h0123;
      step();
      rq.we16 = 1'b0;
      rq.ptr_op = PTR_DEC;
      step();
      check(rsp.eff_addr, 16'h0122);
      rq.ptr_op = PTR_NONE;
      step();
      check(rsp.ptr_x, 16'h0122);
      check(rsp.ds_rd, 8'h22);
      io_acc(1'b0, IO_SP_HI, 8'h00);
      check(io_rdata, TOP_OF_SRAM_DEF[15:8]);
      io_acc(1'b0, 6'h3C, 8'h00);
      check(io_rdata, 8'h00);
      io_acc(1'b1, IO_SP_LO, 8'h80);
      check(stack_pointer, 16'h0480);
      io_acc(1'b1, IO_FLAGS, 8'h14);
      io_acc(1'b0, IO_FLAGS, 8'h00);
      check(io_rdata, 8'h14);
      run(OP_ALU, 8'h80, 8'h3F);
      check(core_flag_register, 8'h2D);
      run(OP_ALU, 8'h00, 8'h02);
      check(core_flag_register, 8'h2F);
      run(OP_BSAVE);
      check(core_flag_register, 8'h6F);
      foreach (STK_OP[i])
      begin
         run(STK_OP[i]);
         check(stack_pointer, STK_SP[i]);
      end
      irq_en = 8'h24;
      run(OP_NONE, 8'h00, 8'h00, 8'hA4);
      check(irq_flags, 8'hA4);
      check(busy, 1'b0);
      run(OP_SEI);
      check(busy, 1'b0);
      run(OP_NONE);
      wait_pulse(1'b0);
      check(vec_addr, 16'h0003);
      check(irq_flags, 8'hA0);
      check(core_flag_register, 8'h6F);
      check(u_mem.mem[11'h480], PC[7:0]);
      check(u_mem.mem[11'h47F], PC[15:8]);
      run(OP_IRQ_EXIT);
      wait_pulse(1'b1);
      check(pc_value, PC);
      check(core_flag_register, 8'hEF);
      relocate = 1'b1;
      step(3);
      check(busy, 1'b0);
      run(OP_NONE);
      wait_pulse(1'b0);
      check(vec_addr, BOOT_START_DEF + 16'h0006);
      run(OP_IRQ_EXIT);
      wait_pulse(1'b1);
      irq_en = 8'h25;
      irq_ev = 8'h01;
      step();
      irq_ev = 8'h00;
      run(OP_CLI);
      check(busy, 1'b0);
      check(irq_flags, 8'h81);
      irq_clr = 8'h01;
      step();
      check(irq_flags, 8'h80);
      irq_clr = 8'h00;
      is_lvl = 8'h04;
      run(OP_SEI);
      run(OP_NONE);
      check(busy, 1'b0);
      lvl = 8'h04;
      app_lock = 1'b1;
      run(OP_NONE);
      check(busy, 1'b0);
      app_lock = 1'b0;
      sleep = 1'b1;
      step(9);
      check(vec_go, 1'b1);
      check(vec_addr, BOOT_START_DEF + 16'h0003);
      report_and_stop();
   end
endmodule
